// ---- dv/sdram_core_asserts.sv ----
// Concurrent checks on the DRAM core ports
`timescale 1ns/100ps
module sdram_core_asserts (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cke_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [15:0] dq_o,
    input  wire logic        dq_oe_n_o,
    input  wire logic  [7:0] wb_adr_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o
);
    logic rd_cmd;
    logic wr_cmd;
    logic req;
    assign rd_cmd = !cs_n_i && ras_n_i && !cas_n_i && we_n_i;
    assign wr_cmd = !cs_n_i && ras_n_i && !cas_n_i && !we_n_i;
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("bus ack without request");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h0c
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(rst_i) |-> dq_oe_n_o && !wb_ack_o)
        else $error("outputs active after reset");
    a_write_tristate: assert property ($past(cke_i) && wr_cmd |=> dq_oe_n_o)
        else $error("data lines driven after write");
    a_suspend_hold: assert property (!cke_i |=> ##1
        $stable(dq_o) && $stable(dq_oe_n_o)) else $error("output moved");
    a_read_start: assert property ($fell(dq_oe_n_o)
        |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
        else $error("read data without read command");
endmodule

bind sdram_core sdram_core_asserts u_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
);

// ---- dv/sdram_core_test.sv ----
// Self-checking bench for the DRAM core
`timescale 1ns/100ps
module sdram_core_test;
    localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
    localparam logic [3:0] BST = 4'h6, PRE = 4'h2;
    logic        clk, rst, wb_we, wb_cyc, cke, oe_n;
    logic  [7:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat, r;
    logic  [3:0] cmd_n;
    logic [11:0] addr;
    logic  [1:0] bank, mask;
    logic [15:0] dq, q;
    logic        wb_ack;
    int          error_cnt, checks_done, nw;
    logic [15:0] exp [int];

    always #4 clk = ~clk;

    sdram_host_model u_host (.clk_i(clk), .cke_o(cke), .cmd_n_o(cmd_n),
        .addr_o(addr), .bank_o(bank), .mask_o(mask), .dq_o(dq));
    sdram_core u_dut (.clk_i(clk), .rst_i(rst), .cke_i(cke),
        .cs_n_i(cmd_n[3]), .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]),
        .we_n_i(cmd_n[0]), .addr_i(addr), .bank_select_low_i(bank[0]),
        .bank_select_high_i(bank[1]), .lower_byte_mask_i(mask[0]),
        .upper_byte_mask_i(mask[1]), .dq_i(dq), .dq_o(q), .dq_oe_n_o(oe_n),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hf),
        .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

    task automatic chk(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        {wb_adr, wb_we, wb_wdat, wb_cyc} <= {a, w, d, 1'b1};
        @(posedge clk);
        while (wb_ack !== 1'b1) @(posedge clk);
        r = wb_rdat;
        wb_cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_is(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(a, 1'b0, 32'h0);
        chk(n, e, r);
    endtask

    task automatic nop(input logic [15:0] d, input logic e);
        u_host.put(NOP, 2'h0, 12'h0, d, 2'b00, e);
    endtask

    // Beat 0 carries the command and the only mask; columns wrap inside wm
    task automatic wr(input logic [1:0] b, input logic [7:0] c, input int n,
                      input logic [15:0] d, input logic [1:0] m, input logic [7:0] wm);
        logic [7:0]  k;
        logic [15:0] dd;
        for (int i = 0; i < n; i++) begin
            k = (c & ~wm) | ((c + 8'(i)) & wm);
            dd = d + 16'(i);
            u_host.put(i == 0 ? WR : NOP, b, {4'h0, c}, dd, i == 0 ? m : 2'b00, 1'b1);
            if (!(i == 0 && m[1])) exp[int'({b, k})][15:8] = dd[15:8];
            if (!(i == 0 && m[0])) exp[int'({b, k})][7:0] = dd[7:0];
            nw++;
        end
    endtask

    task automatic rd(input int key);
        u_host.put(RD, key[9:8], {4'h0, key[7:0]}, 16'h0, 2'b00, 1'b1);
        repeat (2) nop(16'hffff, 1'b1);
        chk("read word", {15'h0, 1'b0, exp[key]}, {15'h0, oe_n, q});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        {clk, rst, wb_cyc, wb_we, wb_adr, wb_wdat} = {2'b01, 42'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_is(sdram_pkg::REG_MODE, {22'h0, sdram_pkg::MODE_RESET}, "mode");
        bus(8'h0c, 1'b1, 32'hffffffff);
        reg_is(8'h0c, 32'h0, "unmapped");
        bus(sdram_pkg::REG_MODE, 1'b1, 32'h022);
        for (int b = 0; b < 4; b++) u_host.put(ACT, 2'(b), 12'h0, 16'h0, 2'b00, 1'b1);
        for (int c = 16; c < 64; c += 4) begin
            wr(2'h1, 8'(c), 4, {8'h11, 8'(c)}, 2'b00, 8'h03);
            wr(2'h2, 8'(c), 4, {8'h22, 8'(c)}, 2'b00, 8'h03);
        end
        wr(2'h1, 8'h10, 4, 16'ha5a0, 2'b01, 8'h03);
        wr(2'h1, 8'h14, 4, 16'h5a50, 2'b10, 8'h03);
        repeat (2) nop(16'hdead, 1'b1);
        reg_is(sdram_pkg::REG_WCOUNT, 32'(nw), "words");
        $display("test bursts finished");
        wr(2'h2, 8'h20, 2, 16'hb000, 2'b00, 8'h03);
        wr(2'h2, 8'h24, 2, 16'hc000, 2'b00, 8'h03);
        u_host.put(RD, 2'h2, 12'h028, 16'hffff, 2'b00, 1'b1);
        repeat (4) nop(16'heeee, 1'b1);
        wr(2'h1, 8'h30, 2, 16'hd000, 2'b00, 8'h03);
        u_host.put(BST, 2'h1, 12'h0, 16'hffff, 2'b00, 1'b1);
        nop(16'heeee, 1'b1);
        reg_is(sdram_pkg::REG_WCOUNT, 32'(nw), "words");
        $display("test truncation finished");
        u_host.put(WR, 2'h2, 12'h030, 16'hf000, 2'b00, 1'b1);
        nop(16'hf001, 1'b0);
        nop(16'hbad0, 1'b1);
        nop(16'hf002, 1'b1);
        nop(16'hf003, 1'b1);
        for (int i = 0; i < 4; i++) exp[int'({2'h2, 8'h30 + 8'(i)})] = 16'hf000 + 16'(i);
        nw += 4;
        bus(sdram_pkg::REG_MODE, 1'b1, 32'h222);
        wr(2'h2, 8'h34, 1, 16'h5a5a, 2'b00, 8'h03);
        repeat (3) nop(16'h0bad, 1'b1);
        bus(sdram_pkg::REG_MODE, 1'b1, 32'h027);
        wr(2'h0, 8'hfe, 3, 16'h7000, 2'b00, 8'hff);
        u_host.put(BST, 2'h0, 12'h0, 16'hffff, 2'b00, 1'b1);
        reg_is(sdram_pkg::REG_WCOUNT, 32'(nw), "words");
        $display("test modes finished");
        bus(sdram_pkg::REG_MODE, 1'b1, 32'h020);
        u_host.put(WR, 2'h3, 12'h405, 16'h3333, 2'b00, 1'b1);
        exp[int'({2'h3, 8'h05})] = 16'h3333;
        nw++;
        repeat (6) nop(16'h0, 1'b1);
        reg_is(sdram_pkg::REG_STATUS, 32'h007, "status");
        u_host.put(PRE, 2'h1, 12'h000, 16'h0, 2'b11, 1'b1);
        nop(16'h0, 1'b1);
        reg_is(sdram_pkg::REG_STATUS, 32'h005, "status");
        u_host.put(WR, 2'h1, 12'h010, 16'h9999, 2'b00, 1'b1);
        nop(16'h0, 1'b1);
        reg_is(sdram_pkg::REG_WCOUNT, 32'(nw), "words");
        u_host.put(PRE, 2'h1, 12'h400, 16'h0, 2'b00, 1'b1);
        nop(16'h0, 1'b1);
        reg_is(sdram_pkg::REG_STATUS, 32'h0, "status");
        repeat (2) nop(16'h0, 1'b0);
        reg_is(sdram_pkg::REG_STATUS, 32'h040, "status");
        repeat (2) nop(16'h0, 1'b1);
        reg_is(sdram_pkg::REG_STATUS, 32'h0, "status");
        u_host.put(ACT, 2'h0, 12'h0, 16'h0, 2'b00, 1'b1);
        repeat (2) nop(16'h0, 1'b0);
        reg_is(sdram_pkg::REG_STATUS, 32'h081, "status");
        repeat (2) nop(16'h0, 1'b1);
        $display("test power finished");
        for (int b = 1; b < 4; b++) u_host.put(ACT, 2'(b), 12'h0, 16'h0, 2'b00, 1'b1);
        repeat (2) nop(16'h0, 1'b1);
        foreach (exp[k]) rd(k);
        $display("test readback finished");
        give_verdict();
    end

    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule

// ---- dv/sdram_host_model.sv ----
// Controller-side pin driver facing the DRAM core
`timescale 1ns/100ps
module sdram_host_model (
    input  wire logic        clk_i,
    output logic             cke_o,
    output logic       [3:0] cmd_n_o,
    output logic      [11:0] addr_o,
    output logic       [1:0] bank_o,
    output logic       [1:0] mask_o,
    output logic      [15:0] dq_o
);
    initial begin
        {cke_o, cmd_n_o, bank_o, addr_o, mask_o, dq_o} = {5'h1f, 32'h0};
    end

    // One command per cycle; masks travel with their own data word
    task automatic put(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic [15:0] d,
                       input logic [1:0] m, input logic e);
        {cke_o, cmd_n_o, bank_o, addr_o, mask_o, dq_o} <= {e, c, b, a, m, d};
        @(posedge clk_i);
    endtask
endmodule

// ---- src/bank_tracker.sv ----
// Open/idle state of one bank with its self-timed precharge
`timescale 1ns/100ps
module bank_tracker (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       activate_i,
    input  wire logic       close_i,
    input  wire logic       arm_i,
    input  wire logic [1:0] delay_i,
    output logic            open_o
);
    logic       pending;
    logic [1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_o <= 1'b0;
        end else if (close_i || (pending && cnt == 2'h0)) begin
            open_o <= 1'b0;
        end else if (activate_i) begin
            open_o <= 1'b1;
        end
    end

    // Auto precharge waits out the given delay, then closes the row
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= 1'b0;
            cnt     <= 2'h0;
        end else if (arm_i) begin
            pending <= 1'b1;
            cnt     <= delay_i;
        end else if (close_i || cnt == 2'h0) begin
            pending <= 1'b0;
        end else if (pending) begin
            cnt     <= cnt - 2'h1;
        end
    end
endmodule

// ---- src/sdram_core.sv ----
// Synchronous DRAM device core: command decode, bursts, power states
//
// Contract
// - First write word taken with WRITE
// - Finished fixed burst ignores further data
// - Full page write wraps, runs until stopped
// - New WRITE any cycle, data is its own
// - READ stops write burst, data ignored
// - BURST TERMINATE ends write, drops its data
// - Address bit ten picks one or all banks
// - Precharged bank idle until activated again
// - Clock enable low with NOP enters power-down
// - NOP with clock enable high leaves power-down
// - Clock enable low during burst suspends clock
// - Suspended edge ignores inputs, holds counters, output
// - Clock enable high resumes on next edge
// - Single write mode bit gives one-column writes
// - Other bank access allowed during auto precharge
// - READ interrupting auto precharge read closes bank
// - WRITE interrupting auto precharge read stops it
// - Write with auto precharge closes row after burst
// - Byte mask acts with zero latency on writes
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module sdram_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cke_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [11:0] addr_i,
    input  wire logic        bank_select_low_i,
    input  wire logic        bank_select_high_i,
    input  wire logic        lower_byte_mask_i,
    input  wire logic        upper_byte_mask_i,
    input  wire logic [15:0] dq_i,
    output logic      [15:0] dq_o,
    output logic             dq_oe_n_o,
    input  wire logic  [7:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic  [3:0] wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    // ------------------------------------------------------------
    // Internal clock gating and command decode
    // ------------------------------------------------------------
    logic               cke_q;
    sdram_pkg::pwr_t    pwr;
    logic         [9:0] mode;
    logic               live;
    sdram_pkg::cmd_t    cmd;
    sdram_pkg::cmd_t    raw_cmd;
    logic         [1:0] bank_in;
    logic         [3:0] bank_open;
    logic               acc_ok;
    logic               new_wr;
    logic               new_rd;
    logic               wsm;
    logic         [2:0] bl_code;
    logic               ilv;
    logic         [2:0] cl;

    assign raw_cmd = sdram_pkg::decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
    // An edge after a low clock enable is suspended: nothing is sampled
    assign live    = cke_q && pwr == sdram_pkg::PWR_RUN;
    assign cmd     = live ? raw_cmd : sdram_pkg::CMD_NOP;
    assign bank_in = {bank_select_high_i, bank_select_low_i};
    assign acc_ok  = bank_open[bank_in];
    assign new_wr  = cmd == sdram_pkg::CMD_WRITE && acc_ok;
    assign new_rd  = cmd == sdram_pkg::CMD_READ && acc_ok;
    assign wsm     = mode[sdram_pkg::MODE_WSM_BIT];
    assign bl_code = mode[sdram_pkg::MODE_BL_LSB +: 3];
    assign ilv     = mode[sdram_pkg::MODE_BT_BIT];
    assign cl      = mode[sdram_pkg::MODE_CL_LSB +: 3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= cke_i;
        end
    end

    // ------------------------------------------------------------
    // Write burst state
    // ------------------------------------------------------------
    logic        wr_active;
    logic  [1:0] wr_bank;
    logic  [7:0] wr_start;
    logic  [8:0] wr_cnt;
    logic  [8:0] wr_len;
    logic        wr_ap;
    logic        wr_stop;
    logic        wr_beat;
    logic        wr_last;
    logic  [8:0] next_wr_len;

    assign wr_stop = new_rd || new_wr
                  || cmd == sdram_pkg::CMD_BST
                  || (cmd == sdram_pkg::CMD_PRE
                      && (addr_i[10] || bank_in == wr_bank));
    // No beat on the edge of READ/BST or of PRE to wr_bank or all banks: that data is dropped
    assign wr_beat = live && wr_active && !wr_stop;
    assign wr_last = wr_len != sdram_pkg::PAGE_COLUMNS
                  && wr_cnt == wr_len - 9'h001;
    assign next_wr_len = wsm ? 9'h001 : sdram_pkg::burst_len(bl_code);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_active <= 1'b0;
            wr_bank   <= 2'h0;
            wr_start  <= 8'h00;
            wr_cnt    <= 9'h000;
            wr_len    <= 9'h001;
            wr_ap     <= 1'b0;
        end else if (new_wr) begin
            wr_active <= next_wr_len != 9'h001;
            wr_bank   <= bank_in;
            wr_start  <= addr_i[7:0];
            wr_cnt    <= 9'h001;
            wr_len    <= next_wr_len;
            wr_ap     <= addr_i[10];
        end else if (wr_stop) begin
            wr_active <= 1'b0;
        end else if (wr_beat) begin
            // A full page burst never ends here; the column wraps
            wr_active <= !wr_last;
            wr_cnt    <= wr_cnt + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Only one row per bank is kept; row address is not stored
    logic [15:0] mem [0:1023];
    logic  [9:0] wr_idx;
    logic        wr_en;
    logic [31:0] wcount;

    assign wr_en  = new_wr || wr_beat;
    assign wr_idx = new_wr ? {bank_in, addr_i[7:0]}
                           : {wr_bank, sdram_pkg::col_at(wr_start, wr_cnt,
                                           wsm ? 3'h0 : bl_code, ilv)};

    always_ff @(posedge clk_i) begin
        if (wr_en && !lower_byte_mask_i) begin
            mem[wr_idx][7:0]  <= dq_i[7:0];
        end
        if (wr_en && !upper_byte_mask_i) begin
            mem[wr_idx][15:8] <= dq_i[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wcount <= 32'h0000_0000;
        end else if (wr_en) begin
            wcount <= wcount + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Read burst state and output pipeline
    // ------------------------------------------------------------
    logic        rd_active;
    logic  [1:0] rd_bank;
    logic  [7:0] rd_start;
    logic  [8:0] rd_cnt;
    logic  [8:0] rd_len;
    logic        rd_ap;
    logic        rd_stop;
    logic        rd_beat;
    logic        rd_last;
    logic  [9:0] rd_idx;
    logic  [1:0] pipe_v;
    logic [15:0] pipe_d [0:1];

    assign rd_stop = new_rd || new_wr
                  || cmd == sdram_pkg::CMD_BST
                  || (cmd == sdram_pkg::CMD_PRE
                      && (addr_i[10] || bank_in == rd_bank));
    assign rd_beat = live && rd_active && !rd_stop;
    assign rd_last = rd_len != sdram_pkg::PAGE_COLUMNS
                  && rd_cnt == rd_len - 9'h001;
    assign rd_idx  = new_rd ? {bank_in, addr_i[7:0]}
                            : {rd_bank, sdram_pkg::col_at(rd_start, rd_cnt,
                                                           bl_code, ilv)};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_active <= 1'b0;
            rd_bank   <= 2'h0;
            rd_start  <= 8'h00;
            rd_cnt    <= 9'h000;
            rd_len    <= 9'h001;
            rd_ap     <= 1'b0;
        end else if (new_rd) begin
            rd_active <= sdram_pkg::burst_len(bl_code) != 9'h001;
            rd_bank   <= bank_in;
            rd_start  <= addr_i[7:0];
            rd_cnt    <= 9'h001;
            rd_len    <= sdram_pkg::burst_len(bl_code);
            rd_ap     <= addr_i[10];
        end else if (rd_stop) begin
            rd_active <= 1'b0;
        end else if (rd_beat) begin
            rd_active <= !rd_last;
            rd_cnt    <= rd_cnt + 9'h001;
        end
    end

    // Pipeline only moves on edges after a high clock enable, so a suspend holds the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pipe_v    <= 2'h0;
            pipe_d[0] <= 16'h0000;
            pipe_d[1] <= 16'h0000;
        end else if (new_wr) begin
            pipe_v    <= 2'h0;
        end else if (cke_q) begin
            pipe_v    <= {pipe_v[0], new_rd || rd_beat};
            pipe_d[0] <= mem[rd_idx];
            pipe_d[1] <= pipe_d[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_o      <= 16'h0000;
            dq_oe_n_o <= 1'b1;
        end else if (new_wr) begin
            dq_oe_n_o <= 1'b1;
        end else if (cke_q) begin
            dq_o      <= cl == sdram_pkg::CL_THREE ? pipe_d[1] : pipe_d[0];
            dq_oe_n_o <= cl == sdram_pkg::CL_THREE ? !pipe_v[1] : !pipe_v[0];
        end
    end

    // ------------------------------------------------------------
    // Banks and auto precharge
    // ------------------------------------------------------------
    logic [3:0] arm;
    logic [1:0] arm_delay [0:3];
    logic       wr_ap_end;
    logic       rd_ap_end;
    logic       other_bank;

    assign wr_ap_end  = wr_active && wr_ap && (wr_stop || (wr_beat
                                                          && wr_last));
    // Auto precharge of a read interrupted by an access to another bank starts at that access
    assign other_bank = (new_rd || new_wr) && bank_in != rd_bank;
    assign rd_ap_end  = rd_active && rd_ap
                     && ((rd_beat && rd_last) || other_bank);

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            arm[b]       = 1'b0;
            arm_delay[b] = sdram_pkg::AP_READ_DELAY;
            if (wr_ap_end && wr_bank == 2'(b)) begin
                arm[b]       = 1'b1;
                arm_delay[b] = sdram_pkg::WR_CYCLES;
            end
            if (rd_ap_end && rd_bank == 2'(b)) begin
                arm[b]       = 1'b1;
            end
            if (new_wr && !wsm && next_wr_len == 9'h001
                && addr_i[10] && bank_in == 2'(b)) begin
                arm[b]       = 1'b1;
                arm_delay[b] = sdram_pkg::WR_CYCLES;
            end
            if (new_wr && wsm && addr_i[10] && bank_in == 2'(b)) begin
                arm[b]       = 1'b1;
                arm_delay[b] = sdram_pkg::WR_CYCLES;
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_bank
        bank_tracker u_bank (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .activate_i (cmd == sdram_pkg::CMD_ACT && bank_in == 2'(b)),
            .close_i    (cmd == sdram_pkg::CMD_PRE
                         && (addr_i[10] || bank_in == 2'(b))),
            .arm_i      (arm[b]),
            .delay_i    (arm_delay[b]),
            .open_o     (bank_open[b])
        );
    end

    // ------------------------------------------------------------
    // Power-down
    // ------------------------------------------------------------
    logic busy;

    assign busy = wr_active || rd_active || |pipe_v;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr <= sdram_pkg::PWR_RUN;
        end else begin
            case (pwr)
                sdram_pkg::PWR_RUN: begin
                    if (cke_q && !cke_i && raw_cmd == sdram_pkg::CMD_NOP
                        && !busy) begin
                        pwr <= |bank_open ? sdram_pkg::PWR_ACT_DOWN
                                          : sdram_pkg::PWR_PRE_DOWN;
                    end
                end
                default: begin
                    if (cke_i && raw_cmd == sdram_pkg::CMD_NOP) begin
                        pwr <= sdram_pkg::PWR_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic        wb_req;
    logic [31:0] status;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign status = {23'h000000,
                     !cke_q && pwr == sdram_pkg::PWR_RUN,
                     pwr == sdram_pkg::PWR_ACT_DOWN,
                     pwr == sdram_pkg::PWR_PRE_DOWN,
                     rd_active, wr_active, bank_open};

    // A mode load command on the pins takes priority over software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= sdram_pkg::MODE_RESET;
        end else if (cmd == sdram_pkg::CMD_LMR) begin
            mode <= addr_i[9:0];
        end else if (wb_req && wb_we_i && wb_adr_i == sdram_pkg::REG_MODE) begin
            if (wb_sel_i[0]) begin
                mode[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                mode[9:8] <= wb_dat_i[9:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_adr_i == sdram_pkg::REG_MODE) begin
                wb_dat_o <= {22'h000000, mode};
            end else if (wb_adr_i == sdram_pkg::REG_STATUS) begin
                wb_dat_o <= status;
            end else if (wb_adr_i == sdram_pkg::REG_WCOUNT) begin
                wb_dat_o <= wcount;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule

// ---- src/sdram_pkg.sv ----
// Shared constants, types and helpers of the synchronous DRAM device core
package sdram_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Wishbone slave)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_MODE   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WCOUNT = 8'h08;

    // ------------------------------------------------------------
    // Mode word layout and reset value
    // ------------------------------------------------------------
    localparam int         MODE_W        = 10;
    localparam int         MODE_BL_LSB   = 0;
    localparam int         MODE_BT_BIT   = 3;
    localparam int         MODE_CL_LSB   = 4;
    localparam int         MODE_WSM_BIT  = 9;
    localparam logic [9:0] MODE_RESET    = 10'h020;
    localparam logic [2:0] CL_THREE      = 3'h3;
    localparam logic [2:0] BL_FULL_PAGE  = 3'h7;
    localparam logic [8:0] PAGE_COLUMNS  = 9'h100;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int STAT_BANK_LSB  = 0;
    localparam int STAT_WR_BIT    = 4;
    localparam int STAT_RD_BIT    = 5;
    localparam int STAT_PPD_BIT   = 6;
    localparam int STAT_APD_BIT   = 7;
    localparam int STAT_SUSP_BIT  = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 8;
    localparam int         WRITE_RECOVERY_NS  = 15;
    localparam int         WR_CYCLES_INT      =
        (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] WR_CYCLES          = WR_CYCLES_INT[1:0];
    localparam logic [1:0] AP_READ_DELAY      = 2'h0;

    // ------------------------------------------------------------
    // Commands and power states
    // ------------------------------------------------------------
    typedef enum {
        CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
        CMD_BST, CMD_PRE, CMD_REF, CMD_LMR
    } cmd_t;

    typedef enum { PWR_RUN, PWR_PRE_DOWN, PWR_ACT_DOWN } pwr_t;

    function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                        input logic cas_n, input logic we_n);
        cmd_t c;
        c = CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3:    c = CMD_ACT;
                3'h5:    c = CMD_READ;
                3'h4:    c = CMD_WRITE;
                3'h6:    c = CMD_BST;
                3'h2:    c = CMD_PRE;
                3'h1:    c = CMD_REF;
                3'h0:    c = CMD_LMR;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [8:0] burst_len(input logic [2:0] code);
        logic [8:0] n;
        case (code)
            3'h0:    n = 9'h001;
            3'h1:    n = 9'h002;
            3'h2:    n = 9'h004;
            3'h3:    n = 9'h008;
            default: n = PAGE_COLUMNS;
        endcase
        return n;
    endfunction

    // Column of beat cnt inside the burst, sequential or interleaved
    function automatic logic [7:0] col_at(input logic [7:0] start,
                                          input logic [8:0] cnt,
                                          input logic [2:0] code,
                                          input logic       ilv);
        logic [7:0] m;
        logic [7:0] off;
        m = burst_len(code) == PAGE_COLUMNS ? 8'hff
                                            : 8'(burst_len(code) - 9'h001);
        off = ilv ? (start ^ cnt[7:0]) : 8'(start + cnt[7:0]);
        return (start & ~m) | (off & m);
    endfunction

endpackage
